// >>> pkg/imsc_map.svh
`ifndef IMSC_MAP_SVH
`define IMSC_MAP_SVH
`define IMSC_C_SET 10'h000
`define IMSC_C_CLR 10'h001
`define IMSC_C_READ 10'h002
`define IMSC_C_MASK_ALL 10'h100
`define IMSC_C_UNMASK_ALL 10'h200
`define IMSC_N_UNIT0 10'h000
`define IMSC_N_UNIT1 10'h001
`define IMSC_N_SCHED 10'h004
`define IMSC_IN_MASK_RST 8'hFF
`define IMSC_IVL_RST 16'h0000
`define IMSC_CLK_MHZ 200
`define IMSC_TU_SHORT_MS 1
`define IMSC_TU_LONG_MS 10
`define IMSC_MS_CYC (`IMSC_CLK_MHZ * 1000)
`define IMSC_TU_SHORT_CYC (`IMSC_TU_SHORT_MS * `IMSC_MS_CYC)
`define IMSC_TU_LONG_CYC (`IMSC_TU_LONG_MS * `IMSC_MS_CYC)
`endif

// >>> pkg/imsc_pkg.sv
package imsc_pkg;
  typedef enum logic [1:0] {
    imsc_idle_s,
    imsc_wait_s,
    imsc_ack_s
  } imsc_svc_state_t;
endpackage : imsc_pkg

// >>> design/imsc_tick.sv
`timescale 1ns/100ps
`include "imsc_map.svh"
// one-cycle pulse per scheduled time unit
module imsc_tick #(
  parameter int unsigned SHORT_CYC = `IMSC_TU_SHORT_CYC,
  parameter int unsigned LONG_CYC = `IMSC_TU_LONG_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic unit_long,
  output logic tick
);
  logic [21:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [21:0] limit;
  assign limit = unit_long ? 22'(LONG_CYC - 1) : 22'(SHORT_CYC - 1);
  always_comb begin
    cnt_d = cnt_q + 22'h000001;
    tick_d = 1'b0;
    if (cnt_q >= limit) begin
      cnt_d = 22'h000000;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 22'h000000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule : imsc_tick

// >>> design/imsc_ctrl.sv
`timescale 1ns/100ps
`include "imsc_map.svh"
module imsc_ctrl
  import imsc_pkg::*;
#(
  parameter int unsigned TU_SHORT_CYC = `IMSC_TU_SHORT_CYC,
  parameter int unsigned TU_LONG_CYC = `IMSC_TU_LONG_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [9:0] op_code,
  input wire logic [9:0] op_type,
  input wire logic [15:0] op_data,
  input wire logic op_addr_bad,
  input wire logic [15:0] irq_in0,
  input wire logic [7:0] irq_in1,
  input wire logic interrupt_response_setting,
  input wire logic pending_work,
  input wire logic scheduled_time_unit_setting,
  input wire logic svc_done,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic error_flag,
  output logic svc_req,
  output logic [4:0] svc_id,
  output logic [15:0] in_mask0,
  output logic global_mask
);
  logic [15:0] in_s1_q, in_s2_q, in_prev_q;
  logic [15:0] mask_q, mask_d, pend_q, pend_d;
  logic gmask_q, gmask_d;
  logic [15:0] ivl_q, ivl_d, cnt_q, cnt_d;
  logic sched_en_q, sched_en_d, sched_pend_q, sched_pend_d;
  logic [15:0] rd_q, rd_d;
  logic rdv_q, rdv_d, err_q, err_d;
  logic [4:0] id_q, id_d;
  imsc_svc_state_t st_q, st_d;
  logic tu_tick, bcd_ok, unit_ok, bad;
  logic [15:0] rise, sel_bits, data_lo;
  logic [3:0] base;
  logic [15:0] pick;
  logic svc_q, svc_d, sched_hit;

  imsc_tick #(
    .SHORT_CYC(TU_SHORT_CYC),
    .LONG_CYC(TU_LONG_CYC)
  ) u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .unit_long(scheduled_time_unit_setting),
    .tick(tu_tick)
  );

  assign bcd_ok = (op_data[3:0] < 4'hA) && (op_data[7:4] < 4'hA) &&
                  (op_data[11:8] < 4'hA) && (op_data[15:12] < 4'hA);
  assign unit_ok = (op_type == `IMSC_N_UNIT0) ||
                   (op_type == `IMSC_N_UNIT1) ||
                   (op_type == `IMSC_N_SCHED);
  assign rise = in_s2_q & ~in_prev_q;
  assign base = (op_type == `IMSC_N_UNIT1) ? 4'h8 : 4'h0;
  assign data_lo = {8'h00, op_data[7:0]};
  assign sel_bits = data_lo << base;
  // lowest pending unmasked input wins; scheduled has lowest priority
  assign pick = pend_q & ~mask_q;
  assign sched_hit = sched_en_q && tu_tick && (cnt_q <= 16'h0001);

  always_comb begin
    mask_d = mask_q;
    gmask_d = gmask_q;
    ivl_d = ivl_q;
    cnt_d = cnt_q;
    sched_en_d = sched_en_q;
    sched_pend_d = sched_pend_q;
    rd_d = rd_q;
    rdv_d = 1'b0;
    err_d = 1'b0;
    bad = 1'b0;
    st_d = st_q;
    id_d = id_q;
    pend_d = pend_q;
    if (op_valid) begin
      bad = op_addr_bad;
      if (op_code == `IMSC_C_MASK_ALL) begin
        if (!bad) gmask_d = 1'b1;
      end else if (op_code == `IMSC_C_UNMASK_ALL) begin
        if (!bad) gmask_d = 1'b0;
      end else if (!unit_ok || !((op_code == `IMSC_C_SET) ||
               (op_code == `IMSC_C_CLR) || (op_code == `IMSC_C_READ))) begin
        bad = 1'b1;
      end else if (op_type == `IMSC_N_SCHED) begin
        if (op_code == `IMSC_C_READ) begin
          if (!bad) begin
            rd_d = ivl_q;
            rdv_d = 1'b1;
          end
        end else if (!bcd_ok) begin
          bad = 1'b1;
        end else if (!bad) begin
          if (op_code == `IMSC_C_SET) begin
            ivl_d = op_data;
            sched_en_d = (op_data != 16'h0000);
          end else begin
            cnt_d = op_data;
          end
        end
      end else if (!bad) begin
        if (op_code == `IMSC_C_SET) begin
          mask_d = (mask_q & ~(16'h00FF << base)) | sel_bits;
        end else if (op_code == `IMSC_C_READ) begin
          rd_d = (mask_q >> base) & 16'h00FF;
          rdv_d = 1'b1;
        end
      end
      err_d = bad;
    end
    // counter decrements in bcd once per time unit
    if (sched_en_q && tu_tick) begin
      if (cnt_q <= 16'h0001) begin
        cnt_d = ivl_q;
        sched_pend_d = 1'b1;
      end else if (cnt_q[11:0] == 12'h000) begin
        cnt_d = cnt_q - 16'h0667;
      end else if (cnt_q[7:0] == 8'h00) begin
        cnt_d = cnt_q - 16'h0067;
      end else if (cnt_q[3:0] == 4'h0) begin
        cnt_d = cnt_q - 16'h0007;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    // latch arrivals even while masked; set wins over clear
    if (op_valid && !bad && unit_ok && op_type != `IMSC_N_SCHED &&
        op_code == `IMSC_C_CLR) begin
      pend_d = pend_q & ~sel_bits;
    end
    pend_d = pend_d | rise;
    case (st_q)
      imsc_idle_s: begin
        if (!gmask_q && (pick != 16'h0000 || sched_pend_q)) begin
          st_d = imsc_wait_s;
        end
      end
      imsc_wait_s: begin
        // a mask-all that lands while waiting must still hold service off
        if (gmask_q) begin
          st_d = imsc_idle_s;
        end else if (!(interrupt_response_setting &&
                     pending_work)) begin
          st_d = imsc_ack_s;
          if (pick != 16'h0000) begin
            for (int i = 15; i >= 0; i--) begin
              if (pick[i]) id_d = 5'(i);
            end
            pend_d = (pend_d & ~(16'h0001 << id_d[3:0])) | rise;
          end else if (sched_pend_q) begin
            id_d = 5'h10;
            // a new expiry in the same cycle wins over the take
            sched_pend_d = sched_hit;
          end else begin
            st_d = imsc_idle_s;
          end
        end
      end
      imsc_ack_s: begin
        if (svc_done) st_d = imsc_idle_s;
      end
      default: st_d = imsc_idle_s;
    endcase
    svc_d = (st_d == imsc_ack_s);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_s1_q <= 16'h0000;
      in_s2_q <= 16'h0000;
      in_prev_q <= 16'h0000;
      mask_q <= {`IMSC_IN_MASK_RST, `IMSC_IN_MASK_RST};
      pend_q <= 16'h0000;
      gmask_q <= 1'b0;
      ivl_q <= `IMSC_IVL_RST;
      cnt_q <= `IMSC_IVL_RST;
      sched_en_q <= 1'b0;
      sched_pend_q <= 1'b0;
      rd_q <= 16'h0000;
      rdv_q <= 1'b0;
      err_q <= 1'b0;
      id_q <= 5'h00;
      st_q <= imsc_idle_s;
      svc_q <= 1'b0;
    end else begin
      in_s1_q <= {irq_in1, irq_in0[7:0]};
      in_s2_q <= in_s1_q;
      in_prev_q <= in_s2_q;
      mask_q <= mask_d;
      pend_q <= pend_d;
      gmask_q <= gmask_d;
      ivl_q <= ivl_d;
      cnt_q <= cnt_d;
      sched_en_q <= sched_en_d;
      sched_pend_q <= sched_pend_d;
      rd_q <= rd_d;
      rdv_q <= rdv_d;
      err_q <= err_d;
      id_q <= id_d;
      st_q <= st_d;
      svc_q <= svc_d;
    end
  end

  assign rd_data = rd_q;
  assign rd_valid = rdv_q;
  assign error_flag = err_q;
  assign svc_req = svc_q;
  assign svc_id = id_q;
  assign in_mask0 = mask_q;
  assign global_mask = gmask_q;
endmodule : imsc_ctrl

// >>> test/imsc_ctrl_chk.sv
`timescale 1ns/100ps
module imsc_ctrl_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [9:0] op_code,
  input wire logic [9:0] op_type,
  input wire logic [15:0] op_data,
  input wire logic op_addr_bad,
  input wire logic rd_valid,
  input wire logic error_flag,
  input wire logic svc_req,
  input wire logic [15:0] in_mask0,
  input wire logic global_mask
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire logic ok = op_valid && !op_addr_bad;
  rst_mask_a: assert property ($rose(reset_n) |-> in_mask0 == 16'hFFFF)
    else $error("reset mask");
  rd_ans_a: assert property (
    ok && op_code == 10'h002 && op_type == 10'h004 |=> rd_valid)
    else $error("read");
  err_src_a: assert property (error_flag |-> $past(op_valid))
    else $error("stray error");
  bad_code_a: assert property (
    op_valid && !(op_code inside {10'h000, 10'h001, 10'h002, 10'h100,
    10'h200}) |=> error_flag && $stable(in_mask0)) else $error("bad code");
  gm_on_a: assert property (
    ok && op_code == 10'h100 |=> global_mask && $stable(in_mask0))
    else $error("mask all");
  gm_off_a: assert property (
    ok && op_code == 10'h200 |=> !global_mask && $stable(in_mask0))
    else $error("unmask all");
  mask_wr_a: assert property (
    ok && op_code == 10'h000 && op_type == 10'h000 && op_data[15:8] == 8'h00
    |=> in_mask0[7:0] == $past(op_data[7:0])) else $error("mask write");
  gm_hold_a: assert property (
    global_mask && $past(global_mask) && !svc_req |=> !svc_req)
    else $error("masked service");
  cover property (error_flag);
  cover property (global_mask && !svc_req);
  cover property ($fell(svc_req));
endmodule : imsc_ctrl_chk
bind imsc_ctrl imsc_ctrl_chk chk_i (.*);

// >>> test/imsc_ctrl_test.sv
`timescale 1ns/100ps
module imsc_ctrl_test;
  logic mclk = 0, reset_n = 0, op_valid = 0, op_addr_bad = 0, svc_done = 0;
  logic interrupt_response_setting = 0, pending_work = 0, global_mask;
  logic scheduled_time_unit_setting = 1, rd_valid, error_flag, svc_req;
  logic [9:0] op_code = 10'h000, op_type = 10'h000;
  logic [15:0] op_data = 16'h0000, irq_in0 = 16'h0000, rd_data, in_mask0;
  logic [7:0] irq_in1 = 8'h00;
  logic [4:0] svc_id;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // short time units keep the scheduled tests well inside the run
  localparam int TU_SHORT = 10;
  localparam int TU_LONG = 20;
  imsc_ctrl #(.TU_SHORT_CYC(TU_SHORT), .TU_LONG_CYC(TU_LONG)) uut (.*);
  always #2.5 mclk = ~mclk;
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic op(input logic [9:0] c, t, input logic [15:0] d,
      input logic bad, err);
    @(posedge mclk);
    op_valid <= 1;
    op_code <= c;
    op_type <= t;
    op_data <= d;
    op_addr_bad <= bad;
    @(posedge mclk);
    op_valid <= 0;
    #1 chk("error_flag", 16'(err), 16'(error_flag));
  endtask : op
  // pin stays high until service starts or 12 cycles pass, so the input sync cannot miss it
  task automatic svc(input logic [7:0] p, input logic on,
      input logic [4:0] id);
    @(posedge mclk);
    irq_in0 <= {8'h00, p};
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk) #1;
      if (svc_req === 1'b1) break;
    end
    chk("svc_req", 16'(on), 16'(svc_req));
    if (on) chk("svc_id", 16'(id), 16'(svc_id));
    @(posedge mclk);
    svc_done <= on;
    irq_in0 <= 16'h0000;
    @(posedge mclk);
    svc_done <= 0;
  endtask : svc
  task automatic t_reset();
    #1 chk("in_mask0", 16'hFFFF, in_mask0);
    op(10'h002, 10'h004, 16'h0000, 0, 0);
    chk("rd_data", 16'h0000, rd_data);
    chk("rd_valid", 16'h0001, 16'(rd_valid));
    svc(8'h01, 0, 5'h00);
    op(10'h001, 10'h000, 16'h00FF, 0, 0);
  endtask : t_reset
  // refused operands must leave the interval at its reset value
  task automatic t_sched();
    op(10'h000, 10'h004, 16'h00A0, 0, 1);
    op(10'h001, 10'h004, 16'h1A00, 0, 1);
    op(10'h003, 10'h004, 16'h0000, 0, 1);
    op(10'h000, 10'h002, 16'h0000, 0, 1);
    op(10'h002, 10'h004, 16'h0000, 0, 0);
    chk("rd_data", 16'h0000, rd_data);
  endtask : t_sched
  // request time is taken from the free cycle counter
  task automatic sched_svc(output int t);
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk) #1;
      if (svc_req === 1'b1) break;
    end
    t = cyc;
    chk("svc_req", 16'h0001, 16'(svc_req));
    chk("svc_id", 16'h0010, 16'(svc_id));
    @(posedge mclk);
    svc_done <= 1;
    @(posedge mclk);
    svc_done <= 0;
  endtask : sched_svc
  task automatic t_period(input logic unit, input int unit_cyc);
    int t0, t1;
    @(posedge mclk);
    scheduled_time_unit_setting <= unit;
    op(10'h001, 10'h004, 16'h0002, 0, 0);
    op(10'h000, 10'h004, 16'h0003, 0, 0);
    op(10'h002, 10'h004, 16'h0000, 0, 0);
    chk("rd_data", 16'h0003, rd_data);
    chk("rd_valid", 16'h0001, 16'(rd_valid));
    sched_svc(t0);
    sched_svc(t1);
    chk("sched_period", 16'(3 * unit_cyc), 16'(t1 - t0));
    op(10'h000, 10'h004, 16'h0000, 0, 0);
  endtask : t_period
  task automatic t_resp();
    @(posedge mclk);
    interrupt_response_setting <= 1;
    pending_work <= 1;
    svc(8'h01, 0, 5'h00);
    @(posedge mclk);
    pending_work <= 0;
    svc(8'h00, 1, 5'h00);
    @(posedge mclk);
    interrupt_response_setting <= 0;
  endtask : t_resp
  task automatic t_mask();
    op(10'h000, 10'h000, 16'h00FE, 0, 0);
    svc(8'h00, 0, 5'h00);
    svc(8'h01, 1, 5'h00);
    op(10'h002, 10'h001, 16'h0000, 0, 0);
    chk("rd_data", 16'h00FF, rd_data);
    chk("rd_valid", 16'h0001, 16'(rd_valid));
  endtask : t_mask
  task automatic t_global();
    op(10'h100, 10'h000, 16'h0000, 1, 1);
    chk("global_mask", 16'h0000, 16'(global_mask));
    op(10'h100, 10'h000, 16'h0000, 0, 0);
    chk("global_mask", 16'h0001, 16'(global_mask));
    svc(8'h01, 0, 5'h00);
    op(10'h200, 10'h000, 16'h0000, 0, 0);
    chk("global_mask", 16'h0000, 16'(global_mask));
    svc(8'h00, 1, 5'h00);
    chk("in_mask0", 16'hFFFE, in_mask0);
  endtask : t_global
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    t_reset();
    t_sched();
    t_period(1'b1, TU_LONG);
    t_period(1'b0, TU_SHORT);
    t_mask();
    t_resp();
    t_global();
    finish_test();
  end
endmodule : imsc_ctrl_test
